//--- common/dsji_pkg.sv
package dsji_pkg;
    localparam int OPW = 16;
    localparam int PCW = 21;
    // opcode patterns: upper six bits, upper eight for the jump, upper four for its second word
    localparam logic [5:0] OP_DSNZ = 6'h13;
    localparam logic [5:0] OP_DSZ = 6'h0b;
    localparam logic [5:0] OP_INC = 6'h0a;
    localparam logic [7:0] OP_JMP1 = 8'hef;
    localparam logic [3:0] OP_JMP2 = 4'hf;
    localparam int DBIT = 9;
    localparam int ABIT = 8;
    localparam logic [3:0] ACCESS_BANK = 4'h0;
    localparam int ST_C = 0;
    localparam int ST_DC = 1;
    localparam int ST_Z = 2;
    localparam int ST_OV = 3;
    localparam int ST_N = 4;
    localparam logic [1:0] PH_DECODE = 2'h0;
    localparam logic [1:0] PH_READ = 2'h1;
    localparam logic [1:0] PH_PROC = 2'h2;
    localparam logic [1:0] PH_WRITE = 2'h3;
    localparam logic [2:0] TWO_WORD_TAG = 3'h7;
    typedef enum logic [1:0] {
        DSJ_RUN = 2'b00,
        DSJ_IDLE1 = 2'b01,
        DSJ_IDLE2 = 2'b10
    } dsji_state_type;
endpackage : dsji_pkg

//--- verilog/dsji_phase.sv
`timescale 1ns/1ns
// four-phase sequencer inside one instruction cycle
module dsji_phase (
    input wire logic core_clk,
    input wire logic sys_rst,
    output logic [1:0] phase,
    output logic cycle_end
);
    import dsji_pkg::*;
    logic [1:0] phase_r;
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            phase_r <= PH_DECODE;
        end else begin
            phase_r <= phase_r + 2'h1;
        end
    end
    assign phase = phase_r;
    assign cycle_end = (phase_r == PH_WRITE);
endmodule : dsji_phase

//--- verilog/dsji_exec.sv
`timescale 1ns/1ns
module dsji_exec (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [dsji_pkg::OPW-1:0] instr_word,
    input wire logic [dsji_pkg::OPW-1:0] next_word,
    input wire logic [7:0] file_rdata,
    input wire logic [3:0] bank_select_register,
    input wire logic [dsji_pkg::PCW-1:0] pc_in,
    output logic [11:0] file_addr,
    output logic file_rd,
    output logic file_we,
    output logic [7:0] file_wdata,
    output logic acc_we,
    output logic [7:0] acc_wdata,
    output logic status_we,
    output logic [4:0] status_wdata,
    output logic pc_we,
    output logic [dsji_pkg::PCW-1:0] pc_wdata,
    output logic idle_slot,
    output logic flush_fetch,
    output logic [1:0] phase_out
);
    import dsji_pkg::*;

    function automatic logic is_two_word(input logic [OPW-1:0] w);
        // jump and other long forms share the 111x prefix group
        is_two_word = (w[15:13] == TWO_WORD_TAG) || (w[15:8] == OP_JMP1);
    endfunction : is_two_word

    logic [1:0] phase;
    logic cycle_end;
    dsji_phase u_phase (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .phase(phase),
        .cycle_end(cycle_end)
    );

    dsji_state_type state_r, state_nxt;
    logic [OPW-1:0] ir_r;
    logic [7:0] opnd_r;
    logic [7:0] klow_r;
    logic [11:0] file_addr_r;
    logic file_rd_r, file_we_r, acc_we_r, status_we_r, pc_we_r;
    logic [7:0] file_wdata_r, acc_wdata_r;
    logic [4:0] status_wdata_r;
    logic [PCW-1:0] pc_wdata_r;
    logic idle_r, flush_r;
    logic [1:0] phase_r;

    logic is_dsnz, is_dsz, is_inc, is_jmp, is_run, dst_file;
    assign is_run = (state_r == DSJ_RUN);
    assign is_dsnz = is_run && (ir_r[15:10] == OP_DSNZ);
    assign is_dsz = is_run && (ir_r[15:10] == OP_DSZ);
    assign is_inc = is_run && (ir_r[15:10] == OP_INC);
    assign is_jmp = is_run && (ir_r[15:8] == OP_JMP1);
    assign dst_file = ir_r[DBIT];

    logic [7:0] dec_v, inc_v;
    logic [8:0] inc_full;
    logic take_skip;
    assign dec_v = opnd_r - 8'h01;
    assign inc_full = {1'b0, opnd_r} + 9'h001;
    assign inc_v = inc_full[7:0];
    logic [7:0] res_v;
    logic [4:0] flag_v;
    assign res_v = is_inc ? inc_v : dec_v;
    always_comb begin
        flag_v = 5'h00;
        flag_v[ST_C] = inc_full[8];
        flag_v[ST_DC] = (opnd_r[3:0] == 4'hf);
        flag_v[ST_Z] = (inc_v == 8'h00);
        flag_v[ST_N] = inc_v[7];
        flag_v[ST_OV] = (opnd_r == 8'h7f);
    end
    // skip decided from the decremented value, flags never consulted
    assign take_skip = (is_dsnz && dec_v != 8'h00) || (is_dsz && dec_v == 8'h00);

    // instruction latch at the start of a cycle; idle cycles keep it for a clean view
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ir_r <= '0;
        end else if (cycle_end && state_nxt == DSJ_RUN) begin
            ir_r <= instr_word;
        end
    end

    always_comb begin
        state_nxt = state_r;
        if (cycle_end) begin
            unique case (state_r)
                DSJ_RUN: begin
                    if (take_skip || is_jmp) begin
                        state_nxt = DSJ_IDLE1;
                    end
                end
                DSJ_IDLE1: begin
                    // a two-word victim costs a second idle slot
                    state_nxt = (flush_r && is_two_word(next_word)) ? DSJ_IDLE2 : DSJ_RUN;
                end
                DSJ_IDLE2: state_nxt = DSJ_RUN;
                default: state_nxt = DSJ_RUN;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_r <= DSJ_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    // datapath phases of one ordinary register cycle
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            opnd_r <= 8'h00;
        end else begin
            if (phase == PH_READ) begin
                opnd_r <= file_rdata;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            file_addr_r <= 12'h000;
            file_rd_r <= 1'b0;
        end else begin
            file_rd_r <= (phase == PH_DECODE) && (state_nxt == DSJ_RUN) &&
                         ((instr_word[15:10] == OP_DSNZ) || (instr_word[15:10] == OP_DSZ) ||
                          (instr_word[15:10] == OP_INC));
            if (phase == PH_DECODE) begin
                file_addr_r <= {instr_word[ABIT] ? bank_select_register : ACCESS_BANK,
                                instr_word[7:0]};
            end
        end
    end

    logic reg_op;
    assign reg_op = is_dsnz || is_dsz || is_inc;
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            file_we_r <= 1'b0;
            acc_we_r <= 1'b0;
            status_we_r <= 1'b0;
            file_wdata_r <= 8'h00;
            acc_wdata_r <= 8'h00;
            status_wdata_r <= 5'h00;
        end else begin
            file_we_r <= (phase == PH_PROC) && reg_op && dst_file;
            acc_we_r <= (phase == PH_PROC) && reg_op && !dst_file;
            status_we_r <= (phase == PH_PROC) && is_inc;
            // data launched with the strobes so it stands during the write phase
            if (phase == PH_PROC) begin
                file_wdata_r <= res_v;
                acc_wdata_r <= res_v;
                status_wdata_r <= flag_v;
            end
        end
    end

    // jump: low literal held at phase two, pc write strobe raised after phase four, in phase one of the next cycle
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            klow_r <= 8'h00;
            pc_we_r <= 1'b0;
            pc_wdata_r <= '0;
        end else begin
            pc_we_r <= 1'b0;
            if (phase == PH_READ && is_jmp) begin
                klow_r <= ir_r[7:0];
            end
            if (phase == PH_WRITE && is_jmp && next_word[15:12] == OP_JMP2) begin
                pc_we_r <= 1'b1;
                pc_wdata_r <= {next_word[11:0], klow_r, pc_in[0]};
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            idle_r <= 1'b0;
            flush_r <= 1'b0;
            phase_r <= PH_DECODE;
        end else begin
            idle_r <= (state_nxt != DSJ_RUN);
            if (cycle_end && state_r == DSJ_RUN) begin
                flush_r <= take_skip;
            end else if (cycle_end && state_nxt == DSJ_RUN) begin
                flush_r <= 1'b0;
            end
            phase_r <= phase + 2'h1;
        end
    end

    assign file_addr = file_addr_r;
    assign file_rd = file_rd_r;
    assign file_we = file_we_r;
    assign file_wdata = file_wdata_r;
    assign acc_we = acc_we_r;
    assign acc_wdata = acc_wdata_r;
    assign status_we = status_we_r;
    assign status_wdata = status_wdata_r;
    assign pc_we = pc_we_r;
    assign pc_wdata = pc_wdata_r;
    assign idle_slot = idle_r;
    assign flush_fetch = flush_r;
    assign phase_out = phase_r;
endmodule : dsji_exec

//--- sim/dsji_exec_monitor.sv
`timescale 1ns/1ns
module dsji_exec_monitor (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [dsji_pkg::PCW-1:0] pc_in,
    input wire logic file_rd,
    input wire logic file_we,
    input wire logic acc_we,
    input wire logic status_we,
    input wire logic pc_we,
    input wire logic [dsji_pkg::PCW-1:0] pc_wdata,
    input wire logic idle_slot,
    input wire logic [1:0] phase_out
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    a_read_phase: assert property (file_rd |-> phase_out == 2'h1)
        else $error("register read outside read phase");
    a_write_phase: assert property ((file_we || acc_we) |-> phase_out == 2'h3)
        else $error("result write outside write phase");
    a_one_dest: assert property (!(file_we && acc_we))
        else $error("result written to both destinations");
    a_idle_quiet: assert property (idle_slot |-> !(file_rd || file_we || acc_we || status_we))
        else $error("activity inside an idle cycle");
    a_flag_with_res: assert property (status_we |-> (file_we || acc_we))
        else $error("flags written without a result");
    a_pc_bit0: assert property (pc_we |-> pc_wdata[0] == pc_in[0])
        else $error("jump changed pc bit 0");
    a_phase_step: assert property (phase_out != 2'h0 |=> phase_out == $past(phase_out) + 2'h1)
        else $error("phase sequence broken");
    a_idle_span: assert property ($rose(idle_slot) |-> idle_slot [*4])
        else $error("idle cycle shorter than four phases");
    a_read_pulse: assert property (file_rd |=> !file_rd)
        else $error("read strobe longer than one clock");
    c_flags: cover property (status_we);
    c_jump: cover property (pc_we);
    c_idle: cover property ($rose(idle_slot));
endmodule : dsji_exec_monitor

//--- sim/dsji_mem_model.sv
`timescale 1ns/1ns
// data memory beside the core; undriven read data shows inverted garbage
module dsji_mem_model (
    input wire logic core_clk,
    input wire logic [11:0] file_addr,
    input wire logic file_rd,
    input wire logic file_we,
    input wire logic [7:0] file_wdata,
    output logic [7:0] file_rdata
);
    logic [7:0] mem [0:4095];
    assign file_rdata = file_rd ? mem[file_addr] : ~mem[file_addr];
    always @(posedge core_clk) begin
        if (file_we) begin
            mem[file_addr] <= file_wdata;
        end
    end
endmodule : dsji_mem_model

//--- sim/tb_dsji_exec.sv
`timescale 1ns/1ns
module tb_dsji_exec;
    import dsji_pkg::*;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [OPW-1:0] instr_word = 16'h0000;
    logic [OPW-1:0] next_word = 16'h0000;
    logic [7:0] file_rdata;
    logic [3:0] bank_select_register = 4'h5;
    logic [PCW-1:0] pc_in = 21'h000000;
    logic [11:0] file_addr;
    logic file_rd, file_we, acc_we, status_we, pc_we, idle_slot, flush_fetch;
    logic [7:0] file_wdata, acc_wdata;
    logic [4:0] status_wdata;
    logic [PCW-1:0] pc_wdata;
    logic [1:0] phase_out;
    int fail_count = 0;
    int n_compared = 0;
    int n_st, n_pc, n_idle, n_flush;
    logic [11:0] rd_a, wr_a;
    logic [7:0] wdat;
    logic [4:0] st;
    logic [PCW-1:0] pcw;
    dsji_exec i_dsji_exec (.core_clk, .sys_rst, .instr_word, .next_word, .file_rdata,
        .bank_select_register, .pc_in, .file_addr, .file_rd, .file_we, .file_wdata, .acc_we,
        .acc_wdata, .status_we, .status_wdata, .pc_we, .pc_wdata, .idle_slot, .flush_fetch,
        .phase_out);
    dsji_mem_model i_dsji_mem_model (.core_clk, .file_addr, .file_rd, .file_we, .file_wdata,
        .file_rdata);
    initial begin
        forever #4 core_clk = ~core_clk;
    end
    // 12'hfff marks a result sent to the accumulator
    always @(posedge core_clk) begin
        if (file_rd) rd_a = file_addr;
        if (file_we || acc_we) wr_a = file_we ? file_addr : 12'hfff;
        if (file_we || acc_we) wdat = file_we ? file_wdata : acc_wdata;
        if (status_we) st = status_wdata;
        if (pc_we) pcw = pc_wdata;
        n_st += status_we;
        n_pc += pc_we;
        n_idle += idle_slot;
        n_flush += flush_fetch;
    end
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // next word is held through fillers: jump and skip look at it late
    task automatic issue(logic [15:0] w, logic [15:0] nw);
        int i;
        i = 0;
        while (phase_out !== 2'h3 && i < 16) begin
            @(negedge core_clk);
            i++;
        end
        if (i >= 16) begin
            fail_count++;
            end_of_test();
        end else begin
            instr_word = w;
            next_word = nw;
            @(negedge core_clk);
        end
    endtask : issue
    task automatic exec(logic [15:0] w, logic [15:0] nw);
        n_st = 0;
        n_pc = 0;
        n_idle = 0;
        n_flush = 0;
        issue(w, nw);
        repeat (3) issue(16'h0000, nw);
    endtask : exec
    task automatic run_reg(logic [5:0] op, logic d, logic a, logic [7:0] f, logic [7:0] v,
        logic [15:0] nw);
        logic [7:0] r;
        logic [11:0] ad;
        logic sk;
        r = (op == OP_INC) ? v + 8'h01 : v - 8'h01;
        ad = a ? {bank_select_register, f} : {ACCESS_BANK, f};
        sk = (op == OP_DSNZ) ? (r != 8'h00) : (op == OP_DSZ) && (r == 8'h00);
        i_dsji_mem_model.mem[ad] = v;
        exec({op, d, a, f}, nw);
        chk("read address", ad, rd_a);
        chk("destination", d ? ad : 12'hfff, wr_a);
        chk("result", r, wdat);
        chk("idle clocks", sk ? ((nw[15:13] == 3'h7) ? 8 : 4) : 0, n_idle);
        chk("flush clocks", sk ? ((nw[15:13] == 3'h7) ? 8 : 4) : 0, n_flush);
        chk("flag writes", op == OP_INC, n_st);
        if (op == OP_INC) begin
            chk("flags", {r[7], v == 8'h7f, r == 8'h00, v[3:0] == 4'hf, v == 8'hff}, st);
        end
    endtask : run_reg
    task automatic run_jmp(logic [19:0] k, logic b0);
        pc_in = {20'h00000, b0};
        exec({OP_JMP1, k[7:0]}, {OP_JMP2, k[19:8]});
        chk("pc", {k, b0}, pcw);
        chk("pc writes", 1, n_pc);
        chk("jump idle clocks", 4, n_idle);
        chk("jump flush clocks", 0, n_flush);
    endtask : run_jmp
    initial begin
        repeat (3) @(negedge core_clk);
        sys_rst = 1'b0;
        @(negedge core_clk);
        run_reg(OP_INC, 1'b0, 1'b0, 8'h20, 8'hff, 16'h0000);
        run_reg(OP_INC, 1'b1, 1'b1, 8'h7f, 8'h7f, 16'h0000);
        run_reg(OP_DSNZ, 1'b1, 1'b0, 8'h30, 8'h05, 16'h0000);
        run_reg(OP_DSNZ, 1'b0, 1'b1, 8'h31, 8'h01, 16'h0000);
        run_reg(OP_DSZ, 1'b1, 1'b1, 8'h40, 8'h01, 16'hef00);
        run_reg(OP_DSZ, 1'b0, 1'b0, 8'h41, 8'h00, 16'h0000);
        run_reg(OP_DSZ, 1'b1, 1'b0, 8'h42, 8'h01, 16'h1234);
        run_jmp(20'hfffff, 1'b1);
        run_jmp(20'h00000, 1'b0);
        run_jmp(20'h5a3c1, 1'b1);
        end_of_test();
    end
endmodule : tb_dsji_exec
bind dsji_exec dsji_exec_monitor i_dsji_exec_monitor (.core_clk, .sys_rst, .pc_in, .file_rd,
    .file_we, .acc_we, .status_we, .pc_we, .pc_wdata, .idle_slot, .phase_out);
